// ===== hw/ubc_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "ubc_regs.svh"
module ubc_device #(
  parameter int RESUME_SHORT_CYC = `UBC_RESUME_SHORT_US * `UBC_CLK_MHZ,
  parameter int RESUME_LONG_CYC = `UBC_RESUME_LONG_MS * 1000 * `UBC_CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  ubc_if.dev bus,
  input wire logic setup_valid_i,
  input wire logic [63:0] setup_data_i,
  input wire logic out_rx_valid_i,
  input wire logic [2:0] out_rx_ep_i,
  input wire logic [6:0] out_rx_count_i,
  output logic [7:0] out_armed_o,
  input wire logic iso_rx_valid_i,
  input wire logic [9:0] iso_rx_count_i,
  input wire logic iso_rx_zero_i,
  input wire logic sof_valid_i,
  input wire logic [10:0] sof_frame_i,
  input wire logic engine_active_i,
  input wire logic bus_suspended_i,
  input wire logic toggle_flip_i,
  input wire logic [2:0] toggle_ep_i,
  input wire logic toggle_in_i,
  output logic [7:0] toggle_in_o,
  output logic [7:0] toggle_out_o,
  output logic [8:0] in_en_o,
  output logic [8:0] out_en_o,
  output logic [7:0] stall_in_o,
  output logic [7:0] stall_out_o,
  output logic [15:0] iso_split_o,
  output logic enable_o,
  output logic pullup_o,
  output logic low_power_o,
  input wire logic iso_in_token_i,
  input wire logic iso_in_ready_i,
  output logic iso_zlp_o,
  output logic line_oe_o,
  output logic line_dp_o,
  output logic line_dm_o,
  input wire logic dma_start_i,
  input wire logic [2:0] dma_start_ep_i,
  output logic dma_req_o,
  output ubc_pkg::ubc_word_t dma_addr_o,
  output logic [6:0] dma_len_o,
  input wire logic dma_done_i,
  input wire logic [6:0] dma_amount_i
);
  import ubc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic ack_ff;
  ubc_word_t rdata_ff;
  logic [39:0] setup_ff;
  logic [6:0] out_size_ff [8];
  logic [7:0] armed_ff;
  logic [9:0] iso_size_ff;
  logic iso_zero_ff;
  logic en_ff, pullup_ff, lowpow_ff, isocfg_ff;
  logic [2:0] line_ff;
  logic [2:0] tog_ep_ff;
  logic tog_dir_ff;
  logic [7:0] tog_in_ff, tog_out_ff;
  logic [8:0] in_en_ff, out_en_ff;
  logic [7:0] stall_in_ff, stall_out_ff;
  logic [15:0] split_ff;
  logic [10:0] frame_ff;
  ubc_word_t ptr_ff [8];
  logic [6:0] max_ff [8];
  logic [6:0] amt_ff [8];
  logic dma_busy_ff;
  logic [2:0] dma_ep_ff;
  logic zlp_ff;
  ubc_word_t rd_mux;

  ////////////////////////////////////////////////////////////////////////
  wire ubc_addr_t a = bus.addr;
  wire take = bus.req & ~ack_ff;
  wire wr = take & bus.we;
  wire hit_size = (a >= `UBC_OFS_OUT_SIZE) && (a < `UBC_OFS_OUT_SIZE_END);
  wire [2:0] size_n = a[4:2];
  wire [11:0] dma_rel = a - `UBC_OFS_IN_DMA;
  wire hit_dma = (a >= `UBC_OFS_IN_DMA) && (a < `UBC_OFS_IN_DMA_END);
  wire [2:0] dma_n = 3'(dma_rel / `UBC_DMA_STRIDE);
  wire [4:0] dma_off = 5'(dma_rel % `UBC_DMA_STRIDE);
  wire [1:0] tog_wval = bus.wdata[`UBC_TOG_VAL_LSB +: 2];
  wire [2:0] wep = bus.wdata[2:0];
  wire wdir = bus.wdata[`UBC_TOG_DIR_BIT];
  wire tog_cur = tog_dir_ff ? tog_in_ff[tog_ep_ff] : tog_out_ff[tog_ep_ff];
  // Shutdown lags the write until the engine reports idle
  wire en_status = en_ff | engine_active_i; // RULE6
  wire force_go = wr && (a == `UBC_OFS_FORCE_TASK);
  wire release_go = wr && (a == `UBC_OFS_RELEASE_TASK);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_mux = '0;
    if (hit_size) begin
      rd_mux = 32'(out_size_ff[size_n]); // RULE3
    end else if (hit_dma) begin
      case (dma_off)
        `UBC_DMA_OFS_PTR: rd_mux = ptr_ff[dma_n]; // RULE20
        `UBC_DMA_OFS_MAX: rd_mux = 32'(max_ff[dma_n]); // RULE20
        `UBC_DMA_OFS_AMOUNT: rd_mux = 32'(amt_ff[dma_n]); // RULE21
        default: rd_mux = '0;
      endcase
    end else begin
      case (a)
        `UBC_OFS_VALUE_HIGH: rd_mux = 32'(setup_ff[7:0]);
        `UBC_OFS_INDEX_LOW: rd_mux = 32'(setup_ff[15:8]); // RULE1
        `UBC_OFS_INDEX_HIGH: rd_mux = 32'(setup_ff[23:16]); // RULE1
        `UBC_OFS_LENGTH_LOW: rd_mux = 32'(setup_ff[31:24]); // RULE2
        `UBC_OFS_LENGTH_HIGH: rd_mux = 32'(setup_ff[39:32]); // RULE2
        `UBC_OFS_ISO_OUT_SIZE: begin
          rd_mux = 32'(iso_size_ff); // RULE5
          rd_mux[`UBC_ISO_ZERO_BIT] = iso_zero_ff; // RULE5
        end
        `UBC_OFS_ENABLE: rd_mux = 32'(en_status); // RULE6
        `UBC_OFS_PULLUP: rd_mux = 32'(pullup_ff);
        `UBC_OFS_LINE_STATE: rd_mux = 32'(line_ff);
        `UBC_OFS_TOGGLE: begin
          rd_mux = 32'(tog_ep_ff); // RULE11
          rd_mux[`UBC_TOG_DIR_BIT] = tog_dir_ff;
          rd_mux[`UBC_TOG_VAL_LSB +: 2] = tog_cur ? `UBC_TOG_DATA1 : `UBC_TOG_DATA0;
        end
        `UBC_OFS_IN_EN: rd_mux = 32'(in_en_ff);
        `UBC_OFS_OUT_EN: rd_mux = 32'(out_en_ff);
        `UBC_OFS_ISO_SPLIT: rd_mux = 32'(split_ff);
        `UBC_OFS_FRAME: rd_mux = 32'(frame_ff); // RULE16
        `UBC_OFS_LOW_POWER: rd_mux = 32'(lowpow_ff);
        `UBC_OFS_ISO_IN_CFG: rd_mux = 32'(isocfg_ff);
        default: rd_mux = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= take;
      if (take) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_ff <= '0;
      iso_size_ff <= 10'(`UBC_RST_ISO_SIZE);
      iso_zero_ff <= 1'(`UBC_RST_ISO_SIZE >> `UBC_ISO_ZERO_BIT);
      frame_ff <= '0;
    end else begin
      if (setup_valid_i) begin
        setup_ff <= setup_data_i[63:24]; // RULE1 RULE2
      end
      if (iso_rx_valid_i) begin
        iso_size_ff <= iso_rx_count_i; // RULE5
        iso_zero_ff <= iso_rx_zero_i;
      end
      if (sof_valid_i) begin
        frame_ff <= sof_frame_i; // RULE16
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_ff <= '0;
      for (int i = 0; i < 8; i++) begin
        out_size_ff[i] <= '0;
      end
    end else begin
      if (out_rx_valid_i) begin
        out_size_ff[out_rx_ep_i] <= out_rx_count_i; // RULE3
        armed_ff[out_rx_ep_i] <= 1'b0;
      end
      // Re-arm beats a reception landing in the same cycle
      if (wr && hit_size) begin
        armed_ff[size_n] <= 1'b1; // RULE4
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff <= 1'b0;
      pullup_ff <= 1'b0; // RULE7
      line_ff <= '0;
      in_en_ff <= `UBC_RST_EP_EN; // RULE12
      out_en_ff <= `UBC_RST_EP_EN; // RULE13
      split_ff <= `UBC_SPLIT_ONE_DIR;
      lowpow_ff <= 1'b0;
      isocfg_ff <= 1'b0;
    end else if (wr) begin
      case (a)
        `UBC_OFS_ENABLE: en_ff <= bus.wdata[0];
        `UBC_OFS_PULLUP: pullup_ff <= bus.wdata[0]; // RULE7
        `UBC_OFS_LINE_STATE: line_ff <= bus.wdata[2:0]; // RULE8
        `UBC_OFS_IN_EN: in_en_ff <= bus.wdata[8:0]; // RULE12
        `UBC_OFS_OUT_EN: out_en_ff <= bus.wdata[8:0]; // RULE13
        `UBC_OFS_ISO_SPLIT: split_ff <= bus.wdata[15:0]; // RULE15
        `UBC_OFS_LOW_POWER: lowpow_ff <= bus.wdata[0];
        `UBC_OFS_ISO_IN_CFG: isocfg_ff <= bus.wdata[0]; // RULE19
        default: en_ff <= en_ff;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tog_ep_ff <= 3'(`UBC_RST_TOGGLE);
      tog_dir_ff <= 1'(`UBC_RST_TOGGLE >> `UBC_TOG_DIR_BIT);
      tog_in_ff <= '0;
      tog_out_ff <= '0;
      stall_in_ff <= '0;
      stall_out_ff <= '0;
    end else begin
      if (toggle_flip_i && toggle_in_i) begin
        tog_in_ff[toggle_ep_i] <= ~tog_in_ff[toggle_ep_i];
      end
      if (toggle_flip_i && !toggle_in_i) begin
        tog_out_ff[toggle_ep_i] <= ~tog_out_ff[toggle_ep_i];
      end
      if (wr && (a == `UBC_OFS_TOGGLE)) begin
        tog_ep_ff <= wep; // RULE11
        tog_dir_ff <= wdir;
        // Software value overrides an engine flip in the same cycle
        if (tog_wval != `UBC_TOG_NOP && wdir) begin
          tog_in_ff[wep] <= tog_wval == `UBC_TOG_DATA1; // RULE11
        end
        if (tog_wval != `UBC_TOG_NOP && !wdir) begin
          tog_out_ff[wep] <= tog_wval == `UBC_TOG_DATA1;
        end
      end
      if (wr && (a == `UBC_OFS_STALL) && wdir) begin
        stall_in_ff[wep] <= bus.wdata[`UBC_STALL_BIT]; // RULE14
      end
      if (wr && (a == `UBC_OFS_STALL) && !wdir) begin
        stall_out_ff[wep] <= bus.wdata[`UBC_STALL_BIT]; // RULE14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_busy_ff <= 1'b0;
      dma_ep_ff <= '0;
      zlp_ff <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        ptr_ff[i] <= '0;
        max_ff[i] <= '0;
        amt_ff[i] <= '0;
      end
    end else begin
      zlp_ff <= iso_in_token_i & ~iso_in_ready_i & isocfg_ff & in_en_ff[8]; // RULE19
      if (wr && hit_dma && dma_off == `UBC_DMA_OFS_PTR) begin
        ptr_ff[dma_n] <= bus.wdata; // RULE20
      end
      if (wr && hit_dma && dma_off == `UBC_DMA_OFS_MAX) begin
        max_ff[dma_n] <= bus.wdata[6:0]; // RULE20
      end
      if (dma_start_i && !dma_busy_ff) begin
        dma_busy_ff <= 1'b1;
        dma_ep_ff <= dma_start_ep_i;
      end else if (dma_done_i && dma_busy_ff) begin
        dma_busy_ff <= 1'b0;
        // Clamped so a misbehaving mover never reports beyond the limit
        amt_ff[dma_ep_ff] <= (dma_amount_i > max_ff[dma_ep_ff]) ?
                             max_ff[dma_ep_ff] : dma_amount_i; // RULE21 RULE22
      end
    end
  end

  ubc_line_force #(
    .SHORT_CYC(RESUME_SHORT_CYC),
    .LONG_CYC(RESUME_LONG_CYC)
  ) u_force (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .drive_i(force_go),
    .release_i(release_go),
    .state_i(line_ff),
    .suspended_i(bus_suspended_i),
    .force_o(line_oe_o),
    .dp_o(line_dp_o),
    .dm_o(line_dm_o)
  );

  assign bus.ack = ack_ff;
  assign bus.rdata = rdata_ff;
  assign out_armed_o = armed_ff;
  assign toggle_in_o = tog_in_ff;
  assign toggle_out_o = tog_out_ff;
  assign in_en_o = in_en_ff; // RULE12
  assign out_en_o = out_en_ff; // RULE13
  assign stall_in_o = stall_in_ff;
  assign stall_out_o = stall_out_ff;
  assign iso_split_o = split_ff; // RULE15
  assign enable_o = en_ff;
  assign pullup_o = pullup_ff; // RULE7
  assign low_power_o = lowpow_ff;
  assign iso_zlp_o = zlp_ff;
  assign dma_req_o = dma_busy_ff;
  assign dma_addr_o = ptr_ff[dma_ep_ff]; // RULE22
  assign dma_len_o = max_ff[dma_ep_ff]; // RULE22
endmodule
`default_nettype wire

// ===== hw/ubc_regs.svh
// Function
// RULE1: Setup index bytes readable as two registers
// RULE2: Setup length bytes readable as two registers
// RULE3: Per OUT endpoint last received byte count
// RULE4: Writing size register re-arms that OUT endpoint
// RULE5: Iso OUT size holds count plus zero flag
// RULE6: Enable reads enabled until shutdown completes
// RULE7: Pull-up bit connects D+ pull-up, resets off
// RULE8: Line state codes resume, J and K
// RULE9: Drive task forces lines, release returns control
// RULE10: Software selects toggle with no-action write first
// RULE11: Toggle register endpoint, direction, value, reset 0x100
// RULE12: IN enables per endpoint, endpoint 0 after reset
// RULE13: OUT enables per endpoint, endpoint 0 after reset
// RULE14: Write-only stall register stalls or unstalls endpoint
// RULE15: Iso split single direction or half and half
// RULE16: Frame counter register returns current frame count
// RULE17: Software writes normal power before remote wake-up
// RULE18: Low power entered only after DMA finished
// RULE19: Iso IN empty answer silent or zero-length
// RULE20: Per IN endpoint DMA pointer and max count
// RULE21: Per IN endpoint bytes moved last transaction
// RULE22: IN DMA reads at most max count at pointer
`ifndef UBC_REGS_SVH
`define UBC_REGS_SVH

`define UBC_OFS_VALUE_HIGH 12'h48c
`define UBC_OFS_INDEX_LOW 12'h490
`define UBC_OFS_INDEX_HIGH 12'h494
`define UBC_OFS_LENGTH_LOW 12'h498
`define UBC_OFS_LENGTH_HIGH 12'h49c
`define UBC_OFS_OUT_SIZE 12'h4a0
`define UBC_OFS_OUT_SIZE_END 12'h4c0
`define UBC_OFS_ISO_OUT_SIZE 12'h4c0
`define UBC_OFS_ENABLE 12'h500
`define UBC_OFS_PULLUP 12'h504
`define UBC_OFS_LINE_STATE 12'h508
`define UBC_OFS_TOGGLE 12'h50c
`define UBC_OFS_IN_EN 12'h510
`define UBC_OFS_OUT_EN 12'h514
`define UBC_OFS_STALL 12'h518
`define UBC_OFS_ISO_SPLIT 12'h51c
`define UBC_OFS_FRAME 12'h520
`define UBC_OFS_LOW_POWER 12'h52c
`define UBC_OFS_ISO_IN_CFG 12'h530
`define UBC_OFS_FORCE_TASK 12'h5f0
`define UBC_OFS_RELEASE_TASK 12'h5f4
`define UBC_OFS_IN_DMA 12'h600
`define UBC_OFS_IN_DMA_END 12'h6a0
`define UBC_DMA_STRIDE 12'h014
`define UBC_DMA_OFS_PTR 5'h00
`define UBC_DMA_OFS_MAX 5'h04
`define UBC_DMA_OFS_AMOUNT 5'h08

`define UBC_RST_TOGGLE 32'h0000_0100
`define UBC_RST_EP_EN 9'h001
`define UBC_RST_ISO_SIZE 32'h0001_0000
`define UBC_ISO_ZERO_BIT 16
`define UBC_TOG_DIR_BIT 7
`define UBC_TOG_VAL_LSB 8
`define UBC_STALL_BIT 8
`define UBC_TOG_NOP 2'h0
`define UBC_TOG_DATA0 2'h1
`define UBC_TOG_DATA1 2'h2
`define UBC_LINE_RESUME 3'h1
`define UBC_LINE_J 3'h2
`define UBC_LINE_K 3'h4
`define UBC_SPLIT_ONE_DIR 16'h0000
`define UBC_SPLIT_HALF 16'h0080
`define UBC_NORMAL_POWER 32'h0000_0000
`define UBC_LOW_POWER 32'h0000_0001

`define UBC_CLK_MHZ 100
`define UBC_RESUME_SHORT_US 50
`define UBC_RESUME_LONG_MS 5

`define UBC_CTL_CMD 8'h00
`define UBC_CTL_WDATA 8'h04
`define UBC_CTL_RDATA 8'h08
`define UBC_CTL_STATUS 8'h0c
`define UBC_OP_LSB 12
`define UBC_OP_READ 3'h0
`define UBC_OP_WRITE 3'h1
`define UBC_OP_TOG_READ 3'h2
`define UBC_OP_TOG_WRITE 3'h3
`define UBC_OP_LP_ENTER 3'h4
`define UBC_OP_LP_LEAVE 3'h5

`endif

// ===== hw/ubc_pkg.sv
package ubc_pkg;
  typedef logic [11:0] ubc_addr_t;
  typedef logic [31:0] ubc_word_t;
  typedef enum logic [1:0] {CS_IDLE, CS_WAIT, CS_REQ, CS_GAP} ubc_ctl_state_e;
  typedef enum logic [1:0] {LF_IDLE, LF_TIMED, LF_HELD} ubc_force_state_e;
endpackage

// ===== hw/ubc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ubc_if;
  import ubc_pkg::*;
  logic req;
  logic we;
  ubc_addr_t addr;
  ubc_word_t wdata;
  ubc_word_t rdata;
  logic ack;
  modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
  modport ctl (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface
`default_nettype wire

// ===== hw/ubc_line_force.sv
`timescale 1ns/10ps
`default_nettype none
`include "ubc_regs.svh"
module ubc_line_force #(
  parameter int SHORT_CYC = 5000,
  parameter int LONG_CYC = 500000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic drive_i,
  input wire logic release_i,
  input wire logic [2:0] state_i,
  input wire logic suspended_i,
  output logic force_o,
  output logic dp_o,
  output logic dm_o
);
  import ubc_pkg::*;
  ubc_force_state_e st_ff;
  logic [19:0] cnt_ff;
  logic dp_ff, dm_ff;
  wire is_resume = state_i == `UBC_LINE_RESUME;
  wire is_j = state_i == `UBC_LINE_J;
  wire legal = is_resume | is_j | (state_i == `UBC_LINE_K);
  // Resume length depends on whether the bus sits in suspend
  wire [19:0] span = suspended_i ? 20'(LONG_CYC - 1) : 20'(SHORT_CYC - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= LF_IDLE;
      cnt_ff <= '0;
      dp_ff <= 1'b0;
      dm_ff <= 1'b0;
    end else if (release_i) begin
      st_ff <= LF_IDLE; // RULE9
    end else if (drive_i && legal) begin
      st_ff <= is_resume ? LF_TIMED : LF_HELD; // RULE9
      cnt_ff <= span; // RULE8
      dp_ff <= is_j; // RULE8
      dm_ff <= ~is_j;
    end else begin
      case (st_ff)
        LF_TIMED: begin
          if (cnt_ff == '0) begin
            st_ff <= LF_IDLE; // RULE8
          end else begin
            cnt_ff <= cnt_ff - 20'd1;
          end
        end
        LF_HELD: st_ff <= LF_HELD;
        default: st_ff <= LF_IDLE;
      endcase
    end
  end

  assign force_o = st_ff != LF_IDLE;
  assign dp_o = dp_ff;
  assign dm_o = dm_ff;
endmodule
`default_nettype wire

// ===== hw/ubc_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "ubc_regs.svh"
module ubc_controller (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire ubc_pkg::ubc_word_t wb_dat_i,
  output ubc_pkg::ubc_word_t wb_dat_o,
  output logic wb_ack_o,
  input wire logic dma_busy_i,
  output logic busy_o,
  ubc_if.ctl bus
);
  import ubc_pkg::*;

  function automatic ubc_word_t merge(ubc_word_t old, ubc_word_t nw, logic [3:0] sel);
    ubc_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  ubc_ctl_state_e st_ff;
  logic wb_ack_ff;
  ubc_word_t wb_dat_ff, cmd_ff, wdat_ff, rdat_ff;
  logic step_ff, req_ff, we_ff;
  ubc_addr_t addr_ff;
  ubc_word_t wd_ff;
  logic s_we;
  ubc_addr_t s_addr;
  ubc_word_t s_data;
  logic two_step;
  ubc_word_t rd_mux;

  wire wb_take = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
  wire wb_wr = wb_take & wb_we_i;
  wire [2:0] op = cmd_ff[`UBC_OP_LSB +: 3];
  wire start = wb_wr && (wb_adr_i == `UBC_CTL_CMD) && (st_ff == CS_IDLE);
  wire ubc_word_t new_cmd = merge(cmd_ff, wb_dat_i, wb_sel_i);
  // Selection write: value field cleared so no toggle is touched
  wire ubc_word_t nop_sel = wdat_ff & ~(32'h0000_0003 << `UBC_TOG_VAL_LSB);

  always_comb begin
    two_step = 1'b0;
    s_we = 1'b1;
    s_addr = cmd_ff[11:0];
    s_data = wdat_ff;
    case (op)
      `UBC_OP_READ: s_we = 1'b0;
      `UBC_OP_TOG_READ, `UBC_OP_TOG_WRITE: begin
        two_step = 1'b1;
        s_addr = `UBC_OFS_TOGGLE;
        s_data = step_ff ? wdat_ff : nop_sel; // RULE10
        s_we = !(step_ff && op == `UBC_OP_TOG_READ);
      end
      `UBC_OP_LP_ENTER: begin
        s_addr = `UBC_OFS_LOW_POWER;
        s_data = `UBC_LOW_POWER; // RULE18
      end
      `UBC_OP_LP_LEAVE: begin
        s_addr = `UBC_OFS_LOW_POWER;
        s_data = `UBC_NORMAL_POWER; // RULE17
      end
      default: s_we = 1'b1;
    endcase
  end

  always_comb begin
    case (wb_adr_i)
      `UBC_CTL_CMD: rd_mux = cmd_ff;
      `UBC_CTL_WDATA: rd_mux = wdat_ff;
      `UBC_CTL_RDATA: rd_mux = rdat_ff;
      `UBC_CTL_STATUS: rd_mux = 32'(st_ff != CS_IDLE);
      default: rd_mux = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= '0;
      cmd_ff <= '0;
      wdat_ff <= '0;
    end else begin
      wb_ack_ff <= wb_take;
      if (wb_take) begin
        wb_dat_ff <= rd_mux;
      end
      if (start) begin
        cmd_ff <= new_cmd;
      end
      // Write data is frozen while a command runs
      if (wb_wr && wb_adr_i == `UBC_CTL_WDATA && st_ff == CS_IDLE) begin
        wdat_ff <= merge(wdat_ff, wb_dat_i, wb_sel_i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= CS_IDLE;
      step_ff <= 1'b0;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      addr_ff <= '0;
      wd_ff <= '0;
      rdat_ff <= '0;
    end else begin
      case (st_ff)
        CS_IDLE: begin
          step_ff <= 1'b0;
          if (start) begin
            st_ff <= CS_WAIT;
          end
        end
        CS_WAIT: begin
          // One access in flight at a time, and low-power entry also waits for DMA to be quiet
          if (!(op == `UBC_OP_LP_ENTER && dma_busy_i)) begin // RULE18
            st_ff <= CS_REQ;
            req_ff <= 1'b1;
            we_ff <= s_we;
            addr_ff <= s_addr;
            wd_ff <= s_data;
          end
        end
        CS_REQ: begin
          if (bus.ack) begin
            req_ff <= 1'b0;
            if (!we_ff) begin
              rdat_ff <= bus.rdata;
            end
            if (two_step && !step_ff) begin
              step_ff <= 1'b1; // RULE10
              st_ff <= CS_GAP;
            end else begin
              st_ff <= CS_IDLE;
            end
          end
        end
        CS_GAP: st_ff <= CS_WAIT;
        default: st_ff <= CS_IDLE;
      endcase
    end
  end

  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign busy_o = st_ff != CS_IDLE;
  assign bus.req = req_ff;
  assign bus.we = we_ff;
  assign bus.addr = addr_ff;
  assign bus.wdata = wd_ff;
endmodule
`default_nettype wire

// ===== dv/ubc_if_props.sv
`timescale 1ns/10ps
`default_nettype none
module ubc_if_props
  import ubc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic we,
  input wire ubc_addr_t addr,
  input wire ubc_word_t wdata,
  input wire ubc_word_t rdata,
  input wire logic ack
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Read data is only meaningful in the ack cycle
  wire logic rd_ack = ack && !we;
  ////////////////////////////////////////
  property p_answer; req && !ack |=> ack; endproperty
  a_answer: assert property (p_answer) else $error("no ack after request");
  property p_pulse; ack |=> !ack && !req; endproperty
  a_pulse: assert property (p_pulse) else $error("ack or req held");
  property p_hold; req && !ack |=> $stable(addr) && $stable(we) && $stable(wdata); endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");
  property p_idx; rd_ack && addr inside {12'h490, 12'h494} |-> rdata[31:8] == 24'h0; endproperty
  a_idx: assert property (p_idx) else $error("index byte too wide");
  property p_len; rd_ack && addr inside {12'h498, 12'h49c} |-> rdata[31:8] == 24'h0; endproperty
  a_len: assert property (p_len) else $error("length byte too wide");
  property p_size; rd_ack && addr inside {[12'h4a0:12'h4bc]} |-> rdata[31:7] == 25'h0; endproperty
  a_size: assert property (p_size) else $error("size too wide");
  property p_en; rd_ack && addr inside {12'h510, 12'h514} |-> rdata[31:9] == 23'h0; endproperty
  a_en: assert property (p_en) else $error("enable bits too wide");
  property p_frame; rd_ack && addr == 12'h520 |-> rdata[31:11] == 21'h0; endproperty
  a_frame: assert property (p_frame) else $error("frame count too wide");
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ubc_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, busy_o;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  ubc_word_t wb_dat_i = 0, wb_dat_o, rd, obs, dma_addr_o, p;
  logic dma_busy_i = 0, setup_valid_i = 0, out_rx_valid_i = 0, iso_rx_valid_i = 0;
  logic iso_rx_zero_i = 0, sof_valid_i = 0, engine_active_i = 0, bus_suspended_i = 0;
  logic toggle_flip_i = 0, toggle_in_i = 0, iso_in_token_i = 0, iso_in_ready_i = 0;
  logic dma_start_i = 0, dma_done_i = 0;
  logic [63:0] setup_data_i = 0;
  logic [2:0] out_rx_ep_i = 0, toggle_ep_i = 0, dma_start_ep_i = 0;
  logic [6:0] out_rx_count_i = 0, dma_amount_i = 0, dma_len_o, m7;
  logic [9:0] iso_rx_count_i = 0;
  logic [10:0] sof_frame_i = 0;
  logic [7:0] out_armed_o, toggle_in_o, toggle_out_o, stall_in_o, stall_out_o;
  logic [8:0] in_en_o, out_en_o, v9;
  logic [15:0] iso_split_o;
  logic enable_o, pullup_o, low_power_o, iso_zlp_o, line_oe_o, line_dp_o, line_dm_o, dma_req_o;
  int n_fail = 0, tests_run = 0, seed = 28056, cnt = 0;
  ubc_word_t q[$];
  string nm;
  event shown;
  always #5 clk_i = ~clk_i;
  ubc_if bus_if();
  ubc_controller ubc_controller_inst(.bus(bus_if), .*);
  // Short resume counts keep the run brief
  ubc_device #(.RESUME_SHORT_CYC(20), .RESUME_LONG_CYC(40)) ubc_device_inst(.bus(bus_if), .*);
  ubc_if_props ubc_if_props_inst(.clk_i, .rst_i, .req(bus_if.req), .we(bus_if.we),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack));
  always @(posedge clk_i) if (line_oe_o) cnt <= cnt + 1;
  ////////////////////////////////////////
  task wb(input logic w, input logic [7:0] a, input ubc_word_t d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hf};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task dv(input logic [2:0] op, input ubc_addr_t a, input ubc_word_t d);
    wb(1, 8'h04, d);
    wb(1, 8'h00, {17'h0, op, a});
    rd = 1;
    for (int i = 0; i < 60 && rd[0] !== 1'b0; i++) wb(0, 8'h0c, 0);
    wb(0, 8'h08, 0);
  endtask
  task lk(input string n, input ubc_word_t e, v);
    q.push_back(e);
    nm = n;
    obs = v;
    ->shown;
    #1;
  endtask
  task r(input ubc_addr_t a, input ubc_word_t e);
    dv(0, a, 0);
    lk("dev_reg", e, rd);
  endtask
  task results;
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(shown) begin
    tests_run++;
    if (obs !== q[0]) begin
      $display("wrong value %s expected %h seen %h", nm, q[0], obs);
      n_fail++;
    end
    void'(q.pop_front());
  end
  initial begin
    #300000;
    n_fail++;
    results();
  end
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    r(12'h50c, 32'h0000_0100);
    r(12'h510, 32'h0000_0001);
    r(12'h514, 32'h0000_0001);
    r(12'h4c0, 32'h0001_0000);
    r(12'h504, 32'h0000_0000);
    @(posedge clk_i);
    {setup_valid_i, setup_data_i} <= {1'b1, $random(seed), $random(seed)};
    {out_rx_valid_i, out_rx_ep_i, out_rx_count_i} <= {4'hb, 7'($random(seed))};
    {iso_rx_valid_i, iso_rx_zero_i, iso_rx_count_i} <= {1'b1, 11'($random(seed))};
    {sof_valid_i, sof_frame_i} <= {1'b1, 11'($random(seed))};
    @(posedge clk_i);
    {setup_valid_i, out_rx_valid_i, iso_rx_valid_i, sof_valid_i} <= 4'h0;
    for (int i = 0; i < 4; i++) r(12'(12'h490 + 4 * i), {24'h0, setup_data_i[32 + 8 * i +: 8]});
    r(12'h4ac, {25'h0, out_rx_count_i});
    lk("armed", 0, {31'h0, out_armed_o[3]});
    dv(1, 12'h4ac, 0);
    lk("armed", 1, {31'h0, out_armed_o[3]});
    r(12'h4c0, {15'h0, iso_rx_zero_i, 6'h0, iso_rx_count_i});
    r(12'h520, {21'h0, sof_frame_i});
    dv(1, 12'h500, 1);
    engine_active_i <= 1;
    dv(1, 12'h500, 0);
    r(12'h500, 1);
    engine_active_i <= 0;
    r(12'h500, 0);
    dv(1, 12'h504, 1);
    lk("pullup", 1, {31'h0, pullup_o});
    for (int s = 2; s <= 4; s += 2) begin
      dv(1, 12'h508, s);
      dv(1, 12'h5f0, 0);
      lk("line", s == 2 ? 6 : 5, {29'h0, line_oe_o, line_dp_o, line_dm_o});
      dv(1, 12'h5f4, 0);
      lk("line", 0, {31'h0, line_oe_o});
    end
    dv(1, 12'h508, 1);
    for (int s = 0; s < 2; s++) begin
      bus_suspended_i <= s[0];
      p = cnt;
      dv(1, 12'h5f0, 0);
      repeat (60) @(posedge clk_i);
      lk("resume", 20 + 20 * s, cnt - p);
    end
    dv(3, 0, 32'h0000_0282);
    lk("toggle", 1, {31'h0, toggle_in_o[2]});
    dv(2, 0, 32'h0000_0082);
    lk("toggle", 32'h0000_0282, rd);
    for (int i = 0; i < 2; i++) begin
      v9 = 9'($random(seed)) | 9'h100;
      dv(1, 12'(12'h510 + 4 * i), {23'h0, v9});
      lk("enables", {23'h0, v9}, {23'h0, i ? out_en_o : in_en_o});
    end
    dv(1, 12'h518, 32'h0000_0185);
    lk("stall", 32'h20, {24'h0, stall_in_o});
    dv(1, 12'h518, 32'h0000_0085);
    lk("stall", 0, {24'h0, stall_in_o});
    dv(1, 12'h51c, 32'h0000_0080);
    lk("split", 32'h80, {16'h0, iso_split_o});
    // Entering low power must wait for the DMA to go quiet
    dma_busy_i <= 1;
    wb(1, 8'h00, {17'h0, 3'h4, 12'h52c});
    repeat (10) @(posedge clk_i);
    lk("lowpwr", 0, {31'h0, low_power_o});
    dma_busy_i <= 0;
    repeat (10) @(posedge clk_i);
    lk("lowpwr", 1, {31'h0, low_power_o});
    dv(5, 12'h52c, 0);
    lk("lowpwr", 0, {31'h0, low_power_o});
    for (int c = 1; c >= 0; c--) begin
      dv(1, 12'h530, c);
      @(posedge clk_i);
      iso_in_token_i <= 1;
      @(posedge clk_i);
      iso_in_token_i <= 0;
      #1;
      lk("zlp", c, {31'h0, iso_zlp_o});
    end
    p = $random(seed);
    m7 = 7'($random(seed));
    dv(1, 12'h628, p);
    dv(1, 12'h62c, {25'h0, m7});
    @(posedge clk_i);
    {dma_start_i, dma_start_ep_i, dma_amount_i} <= {4'ha, m7};
    @(posedge clk_i);
    dma_start_i <= 0;
    #1;
    lk("dma", {p[31:1], 1'b1}, {dma_addr_o[31:1], dma_req_o});
    lk("dma", {25'h0, m7}, {25'h0, dma_len_o});
    @(posedge clk_i);
    dma_done_i <= 1;
    @(posedge clk_i);
    dma_done_i <= 0;
    r(12'h630, {25'h0, m7});
    lk("dma", 0, {31'h0, dma_req_o});
    results();
  end
endmodule
`default_nettype wire
